// ---- dv/cbas_mem_model.sv ----
/* memory side: acks data beats at random and drives read data.
   assumes data beats start two cycles after the address strobe. */
`timescale 1ns/1ps
module cbas_mem_model (
	input wire logic		clk,
	input wire logic		rst_n,
	input wire logic		addr_latch,
	input wire logic		req_ready,
	input wire logic		bus_turnaround_enable,
	input wire logic [3:0]	low_addr_out,
	output logic			mem_ack,
	output logic [31:0]		ad_in
);
	// ==========================================================
	// beat handshake and read data
	integer			seed = 32'h0BADF00D;
	logic			active = 1'b0;
	logic			lead = 1'b0;
	logic [31:0]	last = 32'h0;
	initial begin
		mem_ack = 1'b0;
		ad_in = 32'h0;
	end
	always @(posedge clk) begin
		#1;
		if (!rst_n || req_ready) active = 1'b0;
		mem_ack = active && ($random(seed) & 1);
		if (addr_latch) lead = 1'b1;
		else if (lead) begin
			lead = 1'b0;
			active = 1'b1;
		end
		// released bus shows a toggling pattern, never a stale value
		last = bus_turnaround_enable ? {24'hA5C300, 4'h0, low_addr_out} : ~last;
		ad_in = last;
	end
endmodule

// ---- dv/cbas_top_assertions.sv ----
/* port checker for cbas_top, bound to every instance.
   assumes one clock and a synchronous active-low reset. */
`timescale 1ns/1ps
module cbas_top_assertions (
	input wire logic		clk,
	input wire logic		rst_n,
	input wire logic		req_valid,
	input wire logic		req_ready,
	input wire logic		req_write,
	input wire logic		req_cache_miss,
	input wire logic		req_instr,
	input wire cbas_pkg::cbas_width_t	port_width,
	input wire logic		mem_ack,
	input wire logic		ad_oe,
	input wire logic [3:0]	low_addr_out,
	input wire logic		low_addr_oe,
	input wire logic [3:0]	low_addr_in,
	input wire logic		diag,
	input wire logic		addr_latch,
	input wire logic		bus_turnaround_enable,
	input wire logic		boot_rom_byte_width,
	input wire logic		boot_rom_halfword_width,
	input wire logic		reserved_upper_option,
	input wire logic		extended_address_hold
);
	import cbas_pkg::*;
	// ==========================================================
	// properties
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	wire take = req_valid && req_ready;
	property p_ale; take |=> addr_latch ##1 !addr_latch; endproperty
	a_ale: assert property (p_ale) else $error("strobe not one cycle");
	property p_miss; take && !req_write |=> diag == $past(req_cache_miss); endproperty
	a_miss: assert property (p_miss) else $error("miss phase wrong");
	property p_kind; take && !req_write |=> ##1 diag == $past(req_instr, 2); endproperty
	a_kind: assert property (p_kind) else $error("reference phase wrong");
	property p_turn; bus_turnaround_enable |-> !ad_oe && !$past(ad_oe); endproperty
	a_turn: assert property (p_turn) else $error("turnaround while driving");
	property p_wr_turn; take && req_write |=> !bus_turnaround_enable [*3]; endproperty
	a_wr_turn: assert property (p_wr_turn) else $error("turnaround on write");
	property p_hold; !req_ready && !$past(req_ready) && !$past(mem_ack) |-> $stable(low_addr_out); endproperty
	a_hold: assert property (p_hold) else $error("low select moved mid datum");
	property p_w32; low_addr_oe && port_width == CBAS_PW32 |-> low_addr_out[1:0] == 2'h0; endproperty
	a_w32: assert property (p_w32) else $error("wide port low bits set");
	property p_strap; !$past(rst_n) |-> !low_addr_oe && {boot_rom_halfword_width, boot_rom_byte_width,
		reserved_upper_option, extended_address_hold} == $past(low_addr_in); endproperty
	a_strap: assert property (p_strap) else $error("strap capture wrong");
endmodule

bind cbas_top cbas_top_assertions u_chk (.*);

// ---- dv/cbas_top_bench.sv ----
/* self-checking bench for cbas_top with the memory model.
   assumes the package constants and the hand-over timing. */
`timescale 1ns/1ps
module cbas_top_bench;
	import cbas_pkg::*;
	logic			clk = 1'b0, rst_n = 1'b0, req_valid = 1'b0, req_write = 1'b0, req_burst = 1'b0;
	logic			req_cache_miss = 1'b0, req_instr = 1'b0, big_endian = 1'b0;
	logic			req_ready, mem_ack, ad_oe, low_addr_oe, diag, addr_latch, bus_turnaround_enable, rd_done;
	logic			boot_rom_byte_width, boot_rom_halfword_width, reserved_upper_option, extended_address_hold;
	logic [31:0]	req_addr = 32'h0, req_wdata = 32'h0, ad_in, ad_out, rd_data;
	logic [3:0]		low_addr_in = 4'h0, low_addr_out, byte_lane_en;
	logic [1:0]		rd_index = 2'h0;
	cbas_size_t		req_size = CBAS_SZ_WORD;
	cbas_width_t	port_width = CBAS_PW32;
	integer			seed = 32'h9ded2fbd, mismatches = 0, tests_run = 0;
	logic [8:0]		exp_q[$];
	logic [8:0]		e;
	logic [31:0]	addr_q[$];

	cbas_top u_dut (.*);
	cbas_mem_model u_mem (.*);
	always #2.5 clk = ~clk;

	// ==========================================================
	// checking
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		tests_run++;
		if (seen !== want) begin
			mismatches++;
			$display("ERROR %0t: saw %h want %h", $time, seen, want);
		end
	endtask
	task give_verdict;
		$display("tests_run %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	always @(posedge clk) begin
		if (rst_n && addr_latch === 1'b1) begin
			check(ad_oe, 1);
			if (addr_q.size() == 0) check(1, 0);
			else check(ad_out, addr_q.pop_front());
		end
		if (rst_n && mem_ack === 1'b1 && req_ready === 1'b0) begin
			if (exp_q.size() == 0) check(1, 0);
			else begin
				e = exp_q.pop_front();
				check(low_addr_out, e[3:0]);
				if (e[8]) check(byte_lane_en, e[7:4]);
			end
		end
	end

	// ==========================================================
	// drivers
	task automatic do_reset(input logic [3:0] s);
		@(posedge clk) #1;
		rst_n = 1'b0;
		low_addr_in = s;
		repeat (3) @(posedge clk);
		#1 rst_n = 1'b1;
		@(posedge clk) #1;
		check({boot_rom_halfword_width, boot_rom_byte_width, reserved_upper_option, extended_address_hold}, s);
		low_addr_in = 4'($random(seed));
	endtask
	task automatic xfer(input cbas_width_t w, input logic wr, input logic bu, input cbas_size_t sz);
		logic [31:0] a;
		logic [3:0] la, ln;
		int pb, n;
		a = $random(seed);
		a[1:0] = sz == CBAS_SZ_WORD ? 2'h0 : sz == CBAS_SZ_HALF ? {a[1], 1'b0} : a[1:0];
		pb = w == CBAS_PW32 ? 4 : w == CBAS_PW16 ? 2 : 1;
		port_width = w; req_write = wr; req_burst = bu; req_size = sz; req_addr = a;
		req_wdata = $random(seed); req_cache_miss = 1'($random(seed)); req_instr = 1'($random(seed));
		// bursts exist only for reads
		bu = bu && !wr;
		n = bu ? 16 / pb : ((1 << sz) > pb ? (1 << sz) / pb : 1);
		la = bu ? 4'h0 : 4'(a[3:0] & ~(pb - 1));
		ln = sz == CBAS_SZ_WORD ? 4'hF : sz == CBAS_SZ_HALF ? 4'h3 << a[1:0] : 4'h1 << a[1:0];
		if (big_endian && sz != CBAS_SZ_WORD) ln = {ln[0], ln[1], ln[2], ln[3]};
		for (int i = 0; i < n; i++) exp_q.push_back({w == CBAS_PW32, ln, 4'(la + i * pb)});
		addr_q.push_back(a);
		req_valid = 1'b1;
		while (req_ready !== 1'b1) @(posedge clk) #1;
		@(posedge clk) #1;
		req_valid = 1'b0;
		while (req_ready !== 1'b1) @(posedge clk) #1;
		if (!wr && w == CBAS_PW32 && sz == CBAS_SZ_WORD) begin
			check(rd_done, 1);
			for (int i = 0; i < (bu ? 4 : 1); i++) begin
				rd_index = 2'(i);
				@(posedge clk) #1;
				check(rd_data, {24'hA5C300, 4'h0, bu ? 4'(i * 4) : la});
			end
		end
	endtask

	// ==========================================================
	// sequence and watchdog
	initial begin
		do_reset(4'hA);
		for (int w = 0; w < 3; w++)
			for (int s = 0; s < 3; s++) begin
				big_endian = 1'($random(seed));
				xfer(cbas_width_t'(w), 1'b1, 1'b1, cbas_size_t'(s));
				xfer(cbas_width_t'(w), 1'b0, 1'b0, cbas_size_t'(s));
			end
		for (int w = 0; w < 3; w++) xfer(cbas_width_t'(w), 1'b0, 1'b1, CBAS_SZ_WORD);
		do_reset(4'h5);
		xfer(CBAS_PW32, 1'b0, 1'b1, CBAS_SZ_WORD);
		check(exp_q.size(), 0);
		check(addr_q.size(), 0);
		give_verdict();
	end
	initial begin
		#20000;
		mismatches++;
		give_verdict();
	end
endmodule

// ---- hw/cbas_low_addr.sv ----
/*
 * Low word-select counter: loads a start address and steps by the port width.
 * Assumes the sequencer loads once per transfer and advances only between data.
 */
`timescale 1ns/1ps
module cbas_low_addr (
	input  wire logic clk,
	input  wire logic rst_n,
	cbas_seq_if.cnt   seq
);
	import cbas_pkg::*;

	logic [3:0] count_reg;
	logic [3:0] step;
	logic [3:0] mask;

	// ==========================================================
	// step and valid-bit mask per port width
	always_comb begin
		case (seq.width)
			CBAS_PW32: begin
				step = 4'h4;
				mask = 4'hC;
			end
			CBAS_PW16: begin
				step = 4'h2;
				mask = 4'hE;
			end
			default: begin
				step = 4'h1;
				mask = 4'hF;
			end
		endcase
	end

	// ==========================================================
	// counter; held between advances so each datum sees a stable value
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			count_reg <= CBAS_LOW_ADDR_RST;
		end else if (seq.load) begin
			count_reg <= seq.start & mask;
		end else if (seq.advance) begin
			count_reg <= (count_reg + step) & mask;
		end
	end

	// masked on the way out so a width change between transfers never shows stale low bits
	assign seq.low_addr = count_reg & mask;
endmodule

// ---- hw/cbas_pkg.sv ----
/*
 * Shared constants and types for the processor bus low-address and status outputs.
 * Assumes a single 200 MHz bus clock and a synchronous active-low reset.
 */
package cbas_pkg;

	// ==========================================================
	// port widths and datum sizes
	typedef enum logic [1:0] {
		CBAS_PW32 = 2'h0,
		CBAS_PW16 = 2'h1,
		CBAS_PW8  = 2'h2
	} cbas_width_t;

	typedef enum logic [1:0] {
		CBAS_SZ_BYTE = 2'h0,
		CBAS_SZ_HALF = 2'h1,
		CBAS_SZ_WORD = 2'h2
	} cbas_size_t;

	// ==========================================================
	// bus sequencer states
	typedef enum logic [3:0] {
		CBAS_ST_IDLE = 4'h1,
		CBAS_ST_ADDR = 4'h2,
		CBAS_ST_TURN = 4'h4,
		CBAS_ST_DATA = 4'h8
	} cbas_state_t;

	// ==========================================================
	// reset-time configuration strap positions on the low address pins
	localparam int CBAS_CFG_HALF_BIT = 3;
	localparam int CBAS_CFG_BYTE_BIT = 2;
	localparam int CBAS_CFG_RSVD_BIT = 1;
	localparam int CBAS_CFG_HOLD_BIT = 0;

	// ==========================================================
	// reset values and counts
	localparam logic [3:0] CBAS_LOW_ADDR_RST = 4'h0;
	localparam logic [3:0] CBAS_BURST_START  = 4'h0;
	localparam logic [4:0] CBAS_BURST_BYTES  = 5'h10;
	localparam int         CBAS_BURST_WORDS  = 4;

endpackage

// ---- hw/cbas_seq_if.sv ----
/*
 * Carrier between the bus sequencer and the low word-select counter.
 * Assumes both ends share the bus clock.
 */
`timescale 1ns/1ps
interface cbas_seq_if;
	import cbas_pkg::*;

	logic        load;
	logic        advance;
	logic [3:0]  start;
	cbas_width_t width;
	logic [3:0]  low_addr;

	modport ctl (output load, output advance, output start, output width, input low_addr);
	modport cnt (input load, input advance, input start, input width, output low_addr);
endinterface

// ---- hw/cbas_top.sv ----
/*
 * Bus sequencer driving the low word-select lines, diagnostic pin, address latch
 * strobe, turnaround enable and byte lanes of the multiplexed address/data bus.
 * Assumes requests arrive synchronous to clk, the memory answers each datum with
 * mem_ack, and the port width and byte order are held stable during a transfer.
 */
`timescale 1ns/1ps
module cbas_top (
	input  wire logic                 clk,
	input  wire logic                 rst_n,
	input  wire logic                 req_valid,
	output logic                      req_ready,
	input  wire logic                 req_write,
	input  wire logic                 req_burst,
	input  wire cbas_pkg::cbas_size_t req_size,
	input  wire logic [31:0]          req_addr,
	input  wire logic [31:0]          req_wdata,
	input  wire logic                 req_cache_miss,
	input  wire logic                 req_instr,
	input  wire cbas_pkg::cbas_width_t port_width,
	input  wire logic                 big_endian,
	input  wire logic                 mem_ack,
	output logic [31:0]               ad_out,
	output logic                      ad_oe,
	input  wire logic [31:0]          ad_in,
	output logic [3:0]                low_addr_out,
	output logic                      low_addr_oe,
	input  wire logic [3:0]           low_addr_in,
	output logic                      diag,
	output logic                      addr_latch,
	output logic                      bus_turnaround_enable,
	output logic [3:0]                byte_lane_en,
	output logic                      rd_done,
	input  wire logic [1:0]           rd_index,
	output logic [31:0]               rd_data,
	output logic                      boot_rom_byte_width,
	output logic                      boot_rom_halfword_width,
	output logic                      reserved_upper_option,
	output logic                      extended_address_hold
);
	import cbas_pkg::*;

	cbas_seq_if seq ();

	cbas_state_t state_reg;
	logic        write_reg;
	logic        burst_reg;
	cbas_size_t  size_reg;
	logic [31:0] addr_reg;
	logic [31:0] wdata_reg;
	logic        miss_reg;
	logic        instr_reg;
	logic [4:0]  beats_reg;
	logic        in_reset_reg;
	logic [31:0] rd_buf [CBAS_BURST_WORDS];
	logic [2:0]  pbytes;
	logic [1:0]  offset;
	logic        last_beat;
	logic [1:0]  lane_addr;

	// ==========================================================
	// helpers
	function automatic logic [2:0] port_bytes(input cbas_width_t w);
		case (w)
			CBAS_PW32: port_bytes = 3'h4;
			CBAS_PW16: port_bytes = 3'h2;
			default:   port_bytes = 3'h1;
		endcase
	endfunction

	function automatic logic [4:0] beat_count(input logic burst, input cbas_size_t sz, input cbas_width_t w);
		logic [4:0] bytes;
		logic [4:0] pb;
		bytes = 5'h1 << sz;
		pb = {2'h0, port_bytes(w)};
		if (burst) begin
			beat_count = CBAS_BURST_BYTES >> (3'h2 - {1'h0, w});
		end else if (bytes > pb) begin
			beat_count = bytes >> (3'h2 - {1'h0, w});
		end else begin
			beat_count = 5'h1;
		end
	endfunction

	// lanes: a span of min(datum, port) bytes at the offset within the port, mirrored for big endian
	function automatic logic [3:0] lanes(input cbas_size_t sz, input cbas_width_t w, input logic be,
			input logic [1:0] a);
		logic [3:0] span;
		logic [3:0] plain;
		logic [2:0] pb;
		logic [1:0] off;
		pb = port_bytes(w);
		off = a & 2'(pb - 3'h1);
		span = 4'((5'h1 << ((3'h1 << sz) < pb ? (3'h1 << sz) : pb)) - 5'h1);
		plain = 4'(span << off);
		case (w)
			CBAS_PW32: lanes = be ? {plain[0], plain[1], plain[2], plain[3]} : plain;
			CBAS_PW16: lanes = be ? {2'h0, plain[0], plain[1]} : {2'h0, plain[1:0]};
			default:   lanes = 4'h1;
		endcase
	endfunction

	assign pbytes    = port_bytes(port_width);
	assign offset    = seq.low_addr[1:0];
	assign last_beat = (beats_reg == 5'h1);
	// wide ports mask the low select bits, so outside bursts the byte offset comes from the captured address
	assign lane_addr = (port_width == CBAS_PW32 && !burst_reg) ? addr_reg[1:0] : seq.low_addr[1:0];
	assign req_ready = (state_reg == CBAS_ST_IDLE) && !in_reset_reg;

	// ==========================================================
	// low word-select counter
	assign seq.width   = port_width;
	// writes ignore the burst flag and always start at the target address
	assign seq.start   = (req_burst && !req_write) ? CBAS_BURST_START : req_addr[3:0];
	assign seq.load    = req_valid && req_ready;
	assign seq.advance = (state_reg == CBAS_ST_DATA) && mem_ack && !last_beat;

	cbas_low_addr u_low_addr (
		.clk   (clk),
		.rst_n (rst_n),
		.seq   (seq)
	);

	// ==========================================================
	// sequencer
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_reg <= CBAS_ST_IDLE;
			beats_reg <= 5'h0;
		end else begin
			case (state_reg)
				CBAS_ST_IDLE: begin
					if (req_valid && req_ready) begin
						state_reg <= CBAS_ST_ADDR;
						beats_reg <= beat_count(req_burst && !req_write, req_size, port_width);
					end
				end
				CBAS_ST_ADDR: state_reg <= CBAS_ST_TURN;
				CBAS_ST_TURN: state_reg <= CBAS_ST_DATA;
				CBAS_ST_DATA: begin
					if (mem_ack) begin
						beats_reg <= beats_reg - 5'h1;
						if (last_beat) begin
							state_reg <= CBAS_ST_IDLE;
						end
					end
				end
				default: state_reg <= CBAS_ST_IDLE;
			endcase
		end
	end

	// ==========================================================
	// request capture
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			write_reg <= 1'b0;
			burst_reg <= 1'b0;
			size_reg  <= CBAS_SZ_BYTE;
			addr_reg  <= 32'h0;
			wdata_reg <= 32'h0;
			miss_reg  <= 1'b0;
			instr_reg <= 1'b0;
		end else if (req_valid && req_ready) begin
			write_reg <= req_write;
			burst_reg <= req_burst && !req_write;
			size_reg  <= req_size;
			addr_reg  <= req_addr;
			wdata_reg <= req_wdata;
			miss_reg  <= req_cache_miss;
			instr_reg <= req_instr;
		end
	end

	// ==========================================================
	// bus pins
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ad_out <= 32'h0;
			ad_oe  <= 1'b0;
		end else begin
			case (state_reg)
				CBAS_ST_IDLE: begin
					ad_oe <= req_valid && req_ready;
					ad_out <= req_addr;
				end
				CBAS_ST_ADDR: begin
					// reads let go of the bus before the turnaround enable rises
					ad_oe  <= write_reg;
					ad_out <= wdata_reg >> {offset, 3'h0};
				end
				CBAS_ST_DATA: begin
					ad_oe  <= write_reg && !(mem_ack && last_beat);
					ad_out <= wdata_reg >> {seq.advance ? 2'(offset + pbytes[1:0]) : offset, 3'h0};
				end
				default: begin
					ad_oe  <= ad_oe;
					ad_out <= ad_out;
				end
			endcase
		end
	end

	always_comb begin
		addr_latch            = (state_reg == CBAS_ST_ADDR);
		bus_turnaround_enable = (state_reg == CBAS_ST_DATA) && !write_reg && !ad_oe;
		low_addr_out          = seq.low_addr;
		low_addr_oe           = !in_reset_reg;
		byte_lane_en          = (state_reg == CBAS_ST_IDLE) ? 4'h0 :
			lanes(burst_reg ? CBAS_SZ_WORD : size_reg, port_width, big_endian, lane_addr);
		case (state_reg)
			CBAS_ST_ADDR: diag = miss_reg && !write_reg;
			CBAS_ST_TURN,
			CBAS_ST_DATA: diag = instr_reg && !write_reg;
			default:      diag = 1'b0;
		endcase
	end

	// ==========================================================
	// read buffer; narrow ports fill the word one port width per beat at the low offset
	always_ff @(posedge clk) begin
		if (state_reg == CBAS_ST_DATA && !write_reg && mem_ack) begin
			for (int b = 0; b < 4; b++) begin
				if (b >= int'(offset) && b < int'(offset) + int'(pbytes)) begin
					rd_buf[burst_reg ? seq.low_addr[3:2] : 2'h0][8*b +: 8] <= ad_in[8*(b - int'(offset)) +: 8];
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rd_done <= 1'b0;
			rd_data <= 32'h0;
		end else begin
			rd_done <= (state_reg == CBAS_ST_DATA) && !write_reg && mem_ack && last_beat;
			rd_data <= rd_buf[rd_index];
		end
	end

	// ==========================================================
	// reset straps: sampled on every clock while reset is held, frozen after release
	always_ff @(posedge clk) begin
		in_reset_reg <= !rst_n;
		if (!rst_n) begin
			boot_rom_halfword_width <= low_addr_in[CBAS_CFG_HALF_BIT];
			boot_rom_byte_width     <= low_addr_in[CBAS_CFG_BYTE_BIT];
			reserved_upper_option   <= low_addr_in[CBAS_CFG_RSVD_BIT];
			extended_address_hold   <= low_addr_in[CBAS_CFG_HOLD_BIT];
		end
	end
endmodule
